// ===== core/opd_decoder.sv
// middle opcode group decoder with second-word tracking
`default_nettype none
module opd_decoder
   import opd_pkg::*;
(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   // fetch side
   input  wire logic              fetchValid,
   input  wire logic [WORD_W-1:0] fetchWord,
   // decoded output
   output logic                   decValid,
   output opd_dec_t               dec,
   output logic                   operandValid,
   output logic [WORD_W-1:0]      operandWord
);

   opd_dec_t          comb;
   logic              expectOperand;
   logic              next_expectOperand;
   logic              next_decValid;
   opd_dec_t          next_dec;
   logic              next_operandValid;
   logic [WORD_W-1:0] next_operandWord;
   logic              takeOp;

   default clocking chk_clk @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // field extraction and opcode match
   always_comb begin
      comb                = '0;
      comb.op             = OP_NONE;
      comb.words          = WORDS_ONE;
      comb.cycles         = CYC_ONE;
      comb.cyclesNotTaken = CYC_ONE;
      comb.indirect       = fetchWord[7];
      comb.address        = fetchWord[6:0];
      comb.shortImm       = fetchWord[7:0];
      comb.condition      = fetchWord[7:0];
      comb.shift          = fetchWord[11:8];
      comb.auxIndex       = fetchWord[2:0];
      if (fetchWord == W_OR_IMM_HIGH) begin
         comb.op     = OP_OR_IMM_HIGH;
         comb.words  = WORDS_TWO;
         comb.cycles = CYC_TWO;
      end else if (fetchWord == W_PRODUCT_TO_ACC) begin
         comb.op = OP_PRODUCT_TO_ACC;
      end else if (fetchWord == W_STACK_TO_ACC) begin
         comb.op = OP_STACK_TO_ACC;
      end else if (fetchWord == W_ACC_TO_STACK) begin
         comb.op = OP_ACC_TO_STACK;
      end else if (fetchWord == W_PRODUCT_MINUS) begin
         comb.op = OP_PRODUCT_MINUS_FROM_ACC;
      end else if (fetchWord == W_SUBROUTINE_EXIT) begin
         comb.op             = OP_SUBROUTINE_EXIT;
         comb.cycles         = CYC_FOUR;
         comb.cyclesNotTaken = CYC_FOUR;
      end else if (fetchWord[15:4] == HI_OR_IMM_SHIFT) begin
         comb.op     = OP_OR_IMM_SHIFT;
         comb.words  = WORDS_TWO;
         comb.cycles = CYC_TWO;
         comb.shift  = fetchWord[3:0];
      end else if (fetchWord[15:4] == HI_FLAG_SET_GROUP) begin
         case (fetchWord[3:0])
            LO_SET_CARRY: comb.op = OP_SET_CARRY;
            LO_SET_OVM:   comb.op = OP_SET_OVERFLOW_MODE;
            LO_SET_TC:    comb.op = OP_SET_TEST_CONTROL;
            LO_SET_XF:    comb.op = OP_SET_EXTERNAL_FLAG;
            LO_SET_SXM:   comb.op = OP_SET_SIGN_EXTEND;
            LO_SET_CNF:   comb.op = OP_SET_BLOCK_PROGRAM;
            LO_SET_INTM:  comb.op = OP_SET_INT_DISABLE;
            default:      comb.op = OP_NONE;
         endcase
      end else if (fetchWord[15:3] == HI_AUX_PTR_LOAD) begin
         comb.op = OP_AUX_POINTER_LOAD;
      end else if (fetchWord[15:10] == HI_COND_EXIT) begin
         comb.op             = OP_CONDITIONAL_EXIT;
         comb.cycles         = CYC_FOUR;
         comb.cyclesNotTaken = CYC_TWO;
      end else if (fetchWord[15:8] == HI_MAC_WITH_MOVE) begin
         comb.op     = OP_MAC_WITH_MOVE;
         comb.words  = WORDS_TWO;
         comb.cycles = CYC_THREE;
      end else if (fetchWord[15:8] == HI_LONG_CONST_ST) begin
         comb.op     = OP_LONG_CONSTANT_STORE;
         comb.words  = WORDS_TWO;
         comb.cycles = CYC_TWO;
      end else if (fetchWord[15:8] == HI_MULTIPLY_PLAIN) begin
         comb.op = OP_MULTIPLY_PLAIN;
      end else if (fetchWord[15:8] == HI_MPY_ACC_PRIOR) begin
         comb.op = OP_MULTIPLY_ACCUMULATE_PRIOR;
      end else if (fetchWord[15:8] == HI_MPY_SUB_PRIOR) begin
         comb.op = OP_MULTIPLY_SUBTRACT_PRIOR;
      end else if (fetchWord[15:8] == HI_LEADING_ALIGN) begin
         comb.op = OP_ACC_LEADING_BIT_ALIGN;
      end else if (fetchWord[15:8] == HI_STACK_TO_MEM) begin
         comb.op = OP_STACK_TO_MEMORY;
      end else if (fetchWord[15:8] == HI_MEM_TO_STACK) begin
         comb.op = OP_MEMORY_TO_STACK;
      end else if (fetchWord[15:8] == HI_REPEAT_IMM) begin
         comb.op = OP_REPEAT_NEXT_IMM;
      end else if (fetchWord[15:8] == HI_REPEAT_MEM) begin
         comb.op = OP_REPEAT_NEXT_MEM;
      end else if (fetchWord[15:8] == HI_AUX_DEC_SHORT) begin
         comb.op = OP_AUX_DECREMENT_SHORT;
      end else if (fetchWord[15:8] == HI_SQUARE_MINUS) begin
         comb.op = OP_SQUARE_MINUS;
      end else if (fetchWord[15:8] == HI_STATUS_ZERO) begin
         comb.op = OP_STATUS_SAVE_ZERO;
      end else if (fetchWord[15:8] == HI_STATUS_ONE) begin
         comb.op = OP_STATUS_SAVE_ONE;
      end else if (fetchWord[15:8] == HI_SUB_SHORT_IMM) begin
         comb.op = OP_SUB_SHORT_IMM;
      end else if (fetchWord[15:11] == HI_ACC_HIGH_SAVE) begin
         comb.op    = OP_ACC_HIGH_SAVE;
         comb.shift = {1'b0, fetchWord[10:8]};
      end else if (fetchWord[15:11] == HI_ACC_LOW_SAVE) begin
         comb.op    = OP_ACC_LOW_SAVE;
         comb.shift = {1'b0, fetchWord[10:8]};
      end else if (fetchWord[15:12] == HI_SUB_SHIFTED) begin
         comb.op = OP_SUB_SHIFTED;
      end
      // only a conditional exit has a shorter not-taken figure; the rest report one count
      if (comb.op != OP_CONDITIONAL_EXIT) comb.cyclesNotTaken = comb.cycles;
      // words outside this group are flagged so the neighbouring decoders can claim them
      comb.illegal = (comb.op == OP_NONE);
   end

   // sequencing of first and second words
   always_comb begin
      next_expectOperand = expectOperand;
      next_decValid      = 1'b0;
      next_dec           = dec;
      next_operandValid  = 1'b0;
      next_operandWord   = operandWord;
      if (fetchValid) begin
         if (expectOperand) begin
            // the constant word never reaches the matcher as an opcode
            next_operandValid  = 1'b1;
            next_operandWord   = fetchWord;
            next_expectOperand = 1'b0;
         end else begin
            next_decValid      = 1'b1;
            next_dec           = comb;
            next_expectOperand = (comb.words == WORDS_TWO);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         expectOperand <= 1'b0;
         decValid      <= 1'b0;
         dec           <= '0;
         operandValid  <= 1'b0;
         operandWord   <= '0;
      end else begin
         expectOperand <= next_expectOperand;
         decValid      <= next_decValid;
         dec           <= next_dec;
         operandValid  <= next_operandValid;
         operandWord   <= next_operandWord;
      end
   end

   // checks
   assign takeOp = fetchValid && !expectOperand;

   mac_move_count_a: assert property (
      takeOp && fetchWord[15:8] == HI_MAC_WITH_MOVE
      |=> decValid && dec.op == OP_MAC_WITH_MOVE && dec.words == WORDS_TWO && dec.cycles == CYC_THREE)
      else $error("mac with move decode wrong");
   multiply_plain_a: assert property (
      takeOp && fetchWord[15:8] == HI_MULTIPLY_PLAIN
      |=> dec.op == OP_MULTIPLY_PLAIN && dec.cycles == CYC_ONE && dec.address == $past(fetchWord[6:0]))
      else $error("plain multiply decode wrong");

   mpy_add_prior_a: assert property (
      takeOp && fetchWord[15:8] == HI_MPY_ACC_PRIOR
      |=> dec.op == OP_MULTIPLY_ACCUMULATE_PRIOR && dec.words == WORDS_ONE)
      else $error("multiply add prior decode wrong");
   mpy_sub_prior_a: assert property (
      takeOp && fetchWord[15:8] == HI_MPY_SUB_PRIOR
      |=> dec.op == OP_MULTIPLY_SUBTRACT_PRIOR && dec.cycles == CYC_ONE)
      else $error("multiply subtract prior decode wrong");
   leading_align_a: assert property (
      takeOp && fetchWord[15:8] == HI_LEADING_ALIGN
      |=> dec.op == OP_ACC_LEADING_BIT_ALIGN && dec.indirect == $past(fetchWord[7]))
      else $error("leading bit align decode wrong");

   or_shift_two_a: assert property (
      takeOp && fetchWord[15:4] == HI_OR_IMM_SHIFT
      |=> dec.op == OP_OR_IMM_SHIFT && dec.words == WORDS_TWO && dec.shift == $past(fetchWord[3:0]))
      else $error("or shifted immediate decode wrong");
   or_high_two_a: assert property (
      takeOp && fetchWord == W_OR_IMM_HIGH
      |=> dec.op == OP_OR_IMM_HIGH && dec.words == WORDS_TWO && dec.cycles == CYC_TWO)
      else $error("or high immediate decode wrong");
   product_load_a: assert property (
      takeOp && fetchWord == W_PRODUCT_TO_ACC
      |=> dec.op == OP_PRODUCT_TO_ACC && dec.words == WORDS_ONE)
      else $error("product to accumulator decode wrong");

   stack_pop_a: assert property (
      takeOp && fetchWord == W_STACK_TO_ACC
      |=> dec.op == OP_STACK_TO_ACC && dec.cycles == CYC_ONE)
      else $error("stack pop decode wrong");
   stack_push_a: assert property (
      takeOp && fetchWord == W_ACC_TO_STACK
      |=> dec.op == OP_ACC_TO_STACK && dec.cycles == CYC_ONE)
      else $error("stack push decode wrong");
   pop_to_memory_a: assert property (
      takeOp && fetchWord[15:8] == HI_STACK_TO_MEM
      |=> dec.op == OP_STACK_TO_MEMORY && dec.cycles == CYC_ONE)
      else $error("stack to memory decode wrong");
   push_from_memory_a: assert property (
      takeOp && fetchWord[15:8] == HI_MEM_TO_STACK
      |=> dec.op == OP_MEMORY_TO_STACK && dec.words == WORDS_ONE)
      else $error("memory to stack decode wrong");

   exit_plain_a: assert property (
      takeOp && fetchWord == W_SUBROUTINE_EXIT
      |=> dec.op == OP_SUBROUTINE_EXIT && dec.cycles == CYC_FOUR && dec.cyclesNotTaken == CYC_FOUR)
      else $error("subroutine exit cycles wrong");
   exit_cycles_a: assert property (
      takeOp && fetchWord[15:10] == HI_COND_EXIT && fetchWord != W_SUBROUTINE_EXIT
      |=> dec.op == OP_CONDITIONAL_EXIT && dec.cycles == CYC_FOUR && dec.cyclesNotTaken == CYC_TWO)
      else $error("conditional exit cycles wrong");
   repeat_count_a: assert property (
      takeOp && fetchWord[15:8] == HI_REPEAT_IMM
      |=> dec.op == OP_REPEAT_NEXT_IMM && dec.shortImm == $past(fetchWord[7:0]))
      else $error("repeat immediate decode wrong");
   repeat_memory_a: assert property (
      takeOp && fetchWord[15:8] == HI_REPEAT_MEM
      |=> dec.op == OP_REPEAT_NEXT_MEM && dec.address == $past(fetchWord[6:0]))
      else $error("repeat from memory decode wrong");

   save_shift_a: assert property (
      takeOp && fetchWord[15:11] == HI_ACC_HIGH_SAVE
      |=> dec.op == OP_ACC_HIGH_SAVE && dec.shift == {1'b0, $past(fetchWord[10:8])})
      else $error("high save shift wrong");
   low_save_a: assert property (
      takeOp && fetchWord[15:11] == HI_ACC_LOW_SAVE
      |=> dec.op == OP_ACC_LOW_SAVE && dec.shift == {1'b0, $past(fetchWord[10:8])})
      else $error("low save shift wrong");
   aux_short_a: assert property (
      takeOp && fetchWord[15:8] == HI_AUX_DEC_SHORT
      |=> dec.op == OP_AUX_DECREMENT_SHORT && dec.shortImm == $past(fetchWord[7:0]))
      else $error("aux short subtract decode wrong");

   flag_carry_a: assert property (
      takeOp && fetchWord == {HI_FLAG_SET_GROUP, LO_SET_CARRY}
      |=> dec.op == OP_SET_CARRY && dec.cycles == CYC_ONE)
      else $error("set carry decode wrong");
   flag_external_a: assert property (
      takeOp && fetchWord == {HI_FLAG_SET_GROUP, LO_SET_XF}
      |=> dec.op == OP_SET_EXTERNAL_FLAG && !dec.illegal)
      else $error("set external flag decode wrong");
   flag_unlisted_a: assert property (
      takeOp && fetchWord == {HI_FLAG_SET_GROUP, 4'h0}
      |=> dec.op == OP_NONE && dec.illegal)
      else $error("unlisted flag code decoded");

   product_minus_a: assert property (
      takeOp && fetchWord == W_PRODUCT_MINUS
      |=> dec.op == OP_PRODUCT_MINUS_FROM_ACC && dec.cycles == CYC_ONE)
      else $error("product subtract decode wrong");
   square_minus_a: assert property (
      takeOp && fetchWord[15:8] == HI_SQUARE_MINUS
      |=> dec.op == OP_SQUARE_MINUS && dec.cycles == CYC_ONE)
      else $error("square subtract decode wrong");
   status_zero_a: assert property (
      takeOp && fetchWord[15:8] == HI_STATUS_ZERO
      |=> dec.op == OP_STATUS_SAVE_ZERO && dec.cycles == CYC_ONE)
      else $error("status zero save decode wrong");
   status_one_a: assert property (
      takeOp && fetchWord[15:8] == HI_STATUS_ONE
      |=> dec.op == OP_STATUS_SAVE_ONE && dec.cycles == CYC_ONE)
      else $error("status one save decode wrong");

   long_store_a: assert property (
      takeOp && fetchWord[15:8] == HI_LONG_CONST_ST
      |=> dec.op == OP_LONG_CONSTANT_STORE && dec.words == WORDS_TWO && dec.cycles == CYC_TWO)
      else $error("long constant store decode wrong");
   sub_shifted_a: assert property (
      takeOp && fetchWord[15:12] == HI_SUB_SHIFTED
      |=> dec.op == OP_SUB_SHIFTED && dec.shift == $past(fetchWord[11:8]))
      else $error("shifted subtract decode wrong");
   sub_short_a: assert property (
      takeOp && fetchWord[15:8] == HI_SUB_SHORT_IMM
      |=> dec.op == OP_SUB_SHORT_IMM && dec.shortImm == $past(fetchWord[7:0]))
      else $error("short subtract decode wrong");
   aux_pointer_a: assert property (
      takeOp && fetchWord[15:3] == HI_AUX_PTR_LOAD
      |=> dec.op == OP_AUX_POINTER_LOAD && dec.auxIndex == $past(fetchWord[2:0]))
      else $error("aux pointer decode wrong");

   operand_skip_a: assert property (
      decValid && dec.words == WORDS_TWO ##0 fetchValid [*1]
      |=> operandValid && !decValid)
      else $error("second word decoded as opcode");
   operand_word_a: assert property (
      operandValid
      |-> !decValid && $past(expectOperand) && operandWord == $past(fetchWord))
      else $error("operand word not captured");
   one_word_a: assert property (
      decValid && dec.words == WORDS_ONE
      |-> dec.cycles == CYC_ONE || dec.cycles == CYC_FOUR)
      else $error("one word cycle count wrong");
   two_word_cycles_a: assert property (
      decValid && dec.words == WORDS_TWO
      |-> dec.cycles != CYC_ONE && dec.cyclesNotTaken == dec.cycles)
      else $error("two word cycle count wrong");

   two_word_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      decValid && dec.op == OP_LONG_CONSTANT_STORE ##[1:4] operandValid);
   cond_exit_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      decValid && dec.op == OP_CONDITIONAL_EXIT);
   back_back_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      decValid ##1 decValid ##1 decValid);
   illegal_c: cover property (@(posedge core_clk) disable iff (!rst_n) decValid && dec.illegal);

endmodule
`default_nettype wire

// ===== core/opd_pkg.sv
// package of opcode classes, opcode patterns, word and cycle counts and the decoded record for the middle opcode decoder
`default_nettype none
package opd_pkg;
   localparam int WORD_W = 16;

   typedef enum logic [5:0] {
      OP_NONE,
      OP_MAC_WITH_MOVE,
      OP_MULTIPLY_PLAIN,
      OP_MULTIPLY_ACCUMULATE_PRIOR,
      OP_MULTIPLY_SUBTRACT_PRIOR,
      OP_ACC_LEADING_BIT_ALIGN,
      OP_OR_IMM_SHIFT,
      OP_OR_IMM_HIGH,
      OP_PRODUCT_TO_ACC,
      OP_STACK_TO_ACC,
      OP_ACC_TO_STACK,
      OP_STACK_TO_MEMORY,
      OP_MEMORY_TO_STACK,
      OP_SUBROUTINE_EXIT,
      OP_CONDITIONAL_EXIT,
      OP_REPEAT_NEXT_IMM,
      OP_REPEAT_NEXT_MEM,
      OP_ACC_HIGH_SAVE,
      OP_ACC_LOW_SAVE,
      OP_AUX_DECREMENT_SHORT,
      OP_SET_CARRY,
      OP_SET_OVERFLOW_MODE,
      OP_SET_TEST_CONTROL,
      OP_SET_EXTERNAL_FLAG,
      OP_SET_SIGN_EXTEND,
      OP_SET_BLOCK_PROGRAM,
      OP_SET_INT_DISABLE,
      OP_PRODUCT_MINUS_FROM_ACC,
      OP_SQUARE_MINUS,
      OP_STATUS_SAVE_ZERO,
      OP_STATUS_SAVE_ONE,
      OP_LONG_CONSTANT_STORE,
      OP_SUB_SHIFTED,
      OP_SUB_SHORT_IMM,
      OP_AUX_POINTER_LOAD
   } opd_op_t;

   // opcode patterns
   localparam logic [7:0]  HI_MAC_WITH_MOVE  = 8'hA3;
   localparam logic [7:0]  HI_MULTIPLY_PLAIN = 8'h54;
   localparam logic [7:0]  HI_MPY_ACC_PRIOR  = 8'h50;
   localparam logic [7:0]  HI_MPY_SUB_PRIOR  = 8'h51;
   localparam logic [7:0]  HI_LEADING_ALIGN  = 8'hA0;
   localparam logic [11:0] HI_OR_IMM_SHIFT   = 12'hBFC;
   localparam logic [15:0] W_OR_IMM_HIGH     = 16'hBE82;
   localparam logic [15:0] W_PRODUCT_TO_ACC  = 16'hBE03;
   localparam logic [15:0] W_STACK_TO_ACC    = 16'hBE32;
   localparam logic [15:0] W_ACC_TO_STACK    = 16'hBE3C;
   localparam logic [7:0]  HI_STACK_TO_MEM   = 8'h8A;
   localparam logic [7:0]  HI_MEM_TO_STACK   = 8'h76;
   localparam logic [15:0] W_SUBROUTINE_EXIT = 16'hEF00;
   localparam logic [5:0]  HI_COND_EXIT      = 6'h3B;
   localparam logic [7:0]  HI_REPEAT_IMM     = 8'hBB;
   localparam logic [7:0]  HI_REPEAT_MEM     = 8'h0B;
   localparam logic [4:0]  HI_ACC_HIGH_SAVE  = 5'h13;
   localparam logic [4:0]  HI_ACC_LOW_SAVE   = 5'h12;
   localparam logic [7:0]  HI_AUX_DEC_SHORT  = 8'h7C;
   localparam logic [11:0] HI_FLAG_SET_GROUP = 12'hBE4;
   localparam logic [3:0]  LO_SET_CARRY      = 4'hF;
   localparam logic [3:0]  LO_SET_OVM        = 4'h3;
   localparam logic [3:0]  LO_SET_TC         = 4'hB;
   localparam logic [3:0]  LO_SET_XF         = 4'hD;
   localparam logic [3:0]  LO_SET_SXM        = 4'h7;
   localparam logic [3:0]  LO_SET_CNF        = 4'h5;
   localparam logic [3:0]  LO_SET_INTM       = 4'h1;
   localparam logic [15:0] W_PRODUCT_MINUS   = 16'hBE05;
   localparam logic [7:0]  HI_SQUARE_MINUS   = 8'h53;
   localparam logic [7:0]  HI_STATUS_ZERO    = 8'h8E;
   localparam logic [7:0]  HI_STATUS_ONE     = 8'h8F;
   localparam logic [7:0]  HI_LONG_CONST_ST  = 8'hAE;
   localparam logic [3:0]  HI_SUB_SHIFTED    = 4'h3;
   localparam logic [7:0]  HI_SUB_SHORT_IMM  = 8'hBA;
   localparam logic [12:0] HI_AUX_PTR_LOAD   = 13'h1171;

   // word and cycle counts
   localparam logic [1:0] WORDS_ONE    = 2'd1;
   localparam logic [1:0] WORDS_TWO    = 2'd2;
   localparam logic [2:0] CYC_ONE      = 3'd1;
   localparam logic [2:0] CYC_TWO      = 3'd2;
   localparam logic [2:0] CYC_THREE    = 3'd3;
   localparam logic [2:0] CYC_FOUR     = 3'd4;

   typedef struct packed {
      opd_op_t     op;
      logic [1:0]  words;
      logic [2:0]  cycles;
      logic [2:0]  cyclesNotTaken;
      logic [6:0]  address;
      logic        indirect;
      logic [7:0]  shortImm;
      logic [3:0]  shift;
      logic [2:0]  auxIndex;
      logic [7:0]  condition;
      logic        illegal;
   } opd_dec_t;
endpackage
`default_nettype wire

// ===== testbench/opd_fetch_model.sv
// fetch unit model feeding instruction words to the decoder
`default_nettype none
module opd_fetch_model
   import opd_pkg::*;
(
   // clock
   input  wire logic              core_clk,
   // bench side
   input  wire logic              offerValid,
   input  wire logic [WORD_W-1:0] offerWord,
   // decoder side
   output logic                   fetchValid,
   output logic [WORD_W-1:0]      fetchWord
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [WORD_W-1:0] lastWord = '0;
   always @(posedge core_clk) begin
      if (offerValid) lastWord <= offerWord;
   end
   // idle bus shows inverted last word so stale data never looks fresh
   assign fetchValid = offerValid;
   assign fetchWord  = offerValid ? offerWord : ~lastWord;
endmodule
`default_nettype wire

// ===== testbench/dsp_core_opcode_decoder_part_test.sv
// self-checking bench of the middle opcode decoder
`default_nettype none
module dsp_core_opcode_decoder_part_test
   import opd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic              core_clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              offerValid = 1'b0;
   logic [WORD_W-1:0] offerWord = '0;
   logic              fetchValid;
   logic [WORD_W-1:0] fetchWord;
   logic              decValid;
   opd_dec_t          dec;
   logic              operandValid;
   logic [WORD_W-1:0] operandWord;
   int                fails = 0;
   int                checks = 0;
   int                cycles = 0;
   integer            seed = 32'h30a5;
   logic [31:0]       r;
   logic              needOp = 1'b0;
   logic              pendValid = 1'b0;
   logic              pendOpnd = 1'b0;
   logic [WORD_W-1:0] w;
   opd_op_t           eo;
   logic [3:0]        sh;

   opd_fetch_model fm (.core_clk(core_clk), .offerValid(offerValid), .offerWord(offerWord),
      .fetchValid(fetchValid), .fetchWord(fetchWord));
   opd_decoder uut (.core_clk(core_clk), .rst_n(rst_n), .fetchValid(fetchValid), .fetchWord(fetchWord),
      .decValid(decValid), .dec(dec), .operandValid(operandValid), .operandWord(operandWord));

   always #4 core_clk = ~core_clk;

   function automatic opd_op_t expOp(input logic [15:0] x);
      casez (x)
         16'hBE82: return OP_OR_IMM_HIGH;
         16'hBE03: return OP_PRODUCT_TO_ACC;
         16'hBE32: return OP_STACK_TO_ACC;
         16'hBE3C: return OP_ACC_TO_STACK;
         16'hEF00: return OP_SUBROUTINE_EXIT;
         16'hBE05: return OP_PRODUCT_MINUS_FROM_ACC;
         16'hBFC?: return OP_OR_IMM_SHIFT;
         16'hBE4?: case (x[3:0])
            4'hF: return OP_SET_CARRY;
            4'h3: return OP_SET_OVERFLOW_MODE;
            4'hB: return OP_SET_TEST_CONTROL;
            4'hD: return OP_SET_EXTERNAL_FLAG;
            4'h7: return OP_SET_SIGN_EXTEND;
            4'h5: return OP_SET_BLOCK_PROGRAM;
            4'h1: return OP_SET_INT_DISABLE;
            default: return OP_NONE;
         endcase
         16'b1000_1011_1000_1???: return OP_AUX_POINTER_LOAD;
         16'b1110_11??_????_????: return OP_CONDITIONAL_EXIT;
         16'hA3??: return OP_MAC_WITH_MOVE;
         16'h54??: return OP_MULTIPLY_PLAIN;
         16'h50??: return OP_MULTIPLY_ACCUMULATE_PRIOR;
         16'h51??: return OP_MULTIPLY_SUBTRACT_PRIOR;
         16'hA0??: return OP_ACC_LEADING_BIT_ALIGN;
         16'h8A??: return OP_STACK_TO_MEMORY;
         16'h76??: return OP_MEMORY_TO_STACK;
         16'hBB??: return OP_REPEAT_NEXT_IMM;
         16'h0B??: return OP_REPEAT_NEXT_MEM;
         16'h7C??: return OP_AUX_DECREMENT_SHORT;
         16'h53??: return OP_SQUARE_MINUS;
         16'h8E??: return OP_STATUS_SAVE_ZERO;
         16'h8F??: return OP_STATUS_SAVE_ONE;
         16'hAE??: return OP_LONG_CONSTANT_STORE;
         16'hBA??: return OP_SUB_SHORT_IMM;
         16'b1001_1???_????_????: return OP_ACC_HIGH_SAVE;
         16'b1001_0???_????_????: return OP_ACC_LOW_SAVE;
         16'h3???: return OP_SUB_SHIFTED;
         default: return OP_NONE;
      endcase
   endfunction

   function automatic logic [1:0] expWords(input opd_op_t o);
      if (o inside {OP_MAC_WITH_MOVE, OP_OR_IMM_SHIFT, OP_OR_IMM_HIGH, OP_LONG_CONSTANT_STORE}) return 2'd2;
      return 2'd1;
   endfunction

   function automatic logic [2:0] expCyc(input opd_op_t o);
      if (o == OP_MAC_WITH_MOVE) return 3'd3;
      if (o inside {OP_SUBROUTINE_EXIT, OP_CONDITIONAL_EXIT}) return 3'd4;
      return (expWords(o) == 2'd2) ? 3'd2 : 3'd1;
   endfunction

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic send(input logic [15:0] x);
      offerValid <= 1'b1;
      offerWord  <= x;
      @(posedge core_clk);
   endtask

   task automatic idle();
      offerValid <= 1'b0;
      @(posedge core_clk);
   endtask

   // expectation pipeline: what was taken at the last edge shows now
   always @(posedge core_clk) begin
      if (!rst_n) begin
         pendValid = 1'b0;
         needOp = 1'b0;
      end else begin
         eo = expOp(w);
         sh = w[11:8];
         if (eo == OP_OR_IMM_SHIFT) sh = w[3:0];
         if (eo inside {OP_ACC_HIGH_SAVE, OP_ACC_LOW_SAVE}) sh = {1'b0, w[10:8]};
         if (pendValid && pendOpnd) begin
            cmp({decValid, operandValid}, 2'b01);
            cmp(operandWord, w);
         end else if (pendValid) begin
            cmp({decValid, operandValid}, 2'b10);
            cmp(dec.op, eo);
            cmp({dec.words, dec.cycles}, {expWords(eo), expCyc(eo)});
            cmp(dec.cyclesNotTaken, (eo == OP_CONDITIONAL_EXIT) ? 3'd2 : expCyc(eo));
            cmp(dec.illegal, eo == OP_NONE);
            if (eo != OP_NONE) cmp({dec.address, dec.indirect, dec.shortImm}, {w[6:0], w[7], w[7:0]});
            if (eo != OP_NONE) cmp(dec.auxIndex, w[2:0]);
            if (eo != OP_NONE) cmp({dec.shift, dec.condition}, {sh, w[7:0]});
         end else cmp({decValid, operandValid}, 2'b00);
         pendValid = fetchValid;
         pendOpnd = needOp;
         w = fetchWord;
         if (fetchValid) needOp = !needOp && expWords(expOp(fetchWord)) == 2'd2;
      end
   end

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         wrap_up();
      end
   end

   initial begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      #1 cmp({dec.op, operandWord}, '0);
      @(posedge core_clk);
      send(16'hA312);
      send(16'hBE82);
      send(16'h5412);
      send(16'h5099);
      send(16'h51AA);
      send(16'hA07F);
      send(16'hBFC5);
      idle();
      send(16'hA3FF);
      send(16'hBE82);
      send(16'h00F0);
      send(16'hBE03);
      send(16'hBE32);
      send(16'hBE3C);
      send(16'h8A10);
      send(16'h7681);
      send(16'hEF00);
      send(16'hEC3F);
      send(16'hBB05);
      send(16'h0B20);
      send(16'h9D44);
      send(16'h9255);
      send(16'h7CFF);
      for (int i = 0; i < 16; i++) send({12'hBE4, i[3:0]});
      send(16'hBE05);
      send(16'h5301);
      send(16'h8E02);
      send(16'h8F03);
      send(16'hAE05);
      send(16'h1234);
      send(16'h3A12);
      send(16'hBA80);
      send(16'h8B8B);
      send(16'h8B87);
      idle();
      $display("corner words done");
      send(16'hAE05);
      rst_n <= 1'b0;
      idle();
      idle();
      rst_n <= 1'b1;
      send(16'hBE82);
      idle();
      $display("reset between words done");
      repeat (3000) begin
         r = $random(seed);
         if (r[1:0] != 2'b00) send(r[31:16]);
         else idle();
      end
      idle();
      idle();
      $display("random words done");
      wrap_up();
   end
endmodule
`default_nettype wire
